// [inc/hpq_regs.svh]
// Register offsets, field positions, reset values and sizes of the queue
// block. Included by the package users; defines only.
`ifndef HPQ_REGS_SVH
`define HPQ_REGS_SVH

// Register byte offsets on the host address bus
`define HPQ_TXCTL_OFS    8'h70
`define HPQ_TXSTAT_OFS   8'h72
`define HPQ_TXFREE_OFS   8'h78
`define HPQ_TXQCMD_OFS   8'h80
`define HPQ_RXQCMD_OFS   8'h82
`define HPQ_TXPTR_OFS    8'h84
`define HPQ_RXPTR_OFS    8'h86
`define HPQ_IEN_OFS      8'h90
`define HPQ_ISTAT_OFS    8'h92
`define HPQ_TXREQ_OFS    8'h9e
`define HPQ_DATA_OFS     8'hd0

// Transmit control fields
`define HPQ_TXCTL_EN     0
`define HPQ_TXCTL_CRC    1
`define HPQ_TXCTL_PAD    2
`define HPQ_TXCTL_FLOW   3
`define HPQ_TXCTL_MASK   16'h01ef

// Queue command fields
`define HPQ_TXQ_MANUAL   0
`define HPQ_TXQ_SPACE    1
`define HPQ_TXQ_AUTO     2
`define HPQ_RXQ_DMA      3

// Data pointer fields
`define HPQ_PTR_AUTOINC  14
`define HPQ_PTR_BIGEND   11
`define HPQ_TXPTR_MASK   16'h47ff
`define HPQ_RXPTR_MASK   16'h4fff
`define HPQ_PTR_STEP     11'h002

// Interrupt bits
`define HPQ_IRQ_TXDONE   14
`define HPQ_IRQ_SPACE    6

// Frame header fields
`define HPQ_CTL_IRQ      15
`define HPQ_LEN_MSB      10

// Sizes and reset values
`define HPQ_TXQ_BYTES    13'h1800
`define HPQ_MAX_BYTES    11'h7d0
`define HPQ_RESET_WORD   16'h0000

`endif

// [inc/hpq_pkg.sv]
// Types shared by the host packet queue block.
// Widths follow the 16-bit host data path.
package hpq_pkg;

  typedef enum logic [4:0] {
    DR_IDLE = 5'b00001,
    DR_CTRL = 5'b00010,
    DR_LEN  = 5'b00100,
    DR_DATA = 5'b01000,
    DR_DONE = 5'b10000
  } hpq_drain_t;

  typedef enum logic [2:0] {
    FL_CTRL = 3'b001,
    FL_LEN  = 3'b010,
    FL_DATA = 3'b100
  } hpq_fill_t;

  typedef enum logic [2:0] {
    RX_STAT = 3'b001,
    RX_LEN  = 3'b010,
    RX_DATA = 3'b100
  } hpq_rxph_t;

  typedef struct packed {
    logic        wrPrev;
    logic        rdPrev;
    logic [15:0] txCtl;
    logic [15:0] txStat;
    logic [15:0] txQCmd;
    logic [15:0] rxQCmd;
    logic [15:0] txPtr;
    logic [15:0] rxPtr;
    logic [15:0] iEn;
    logic [15:0] iStat;
    logic [15:0] txReq;
    logic [12:0] freeMem;
    hpq_fill_t   fill;
    logic [10:0] fillLeft;
    logic [5:0]  prepared;
    logic [5:0]  queued;
    hpq_drain_t  drain;
    logic [10:0] drainLeft;
    logic [15:0] drainCtl;
    logic [10:0] drainLen;
    logic        fifoPush;
    logic [15:0] fifoWord;
    logic [15:0] busOut;
    logic        busOeN;
    logic        waitN;
    logic [15:0] macData;
    logic        macValid;
    logic        macLast;
    logic        intrN;
    hpq_rxph_t   rxPh;
    logic [10:0] rxLeft;
    logic        rxPop;
    logic        rxDone;
  } hpq_state_t;

endpackage

// [hw/hpq_fifo.sv]
// Word FIFO between host writes and the transmit drain.
// Assumes one clock; flops only, no memory macro.
`timescale 1ns/1ps
module hpq_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } hpq_fifo_state_t;

  hpq_fifo_state_t st;
  hpq_fifo_state_t nx;
  logic            full;
  logic            empty;

  // Full and empty from the wrap bit of the pointers
  assign full     = (st.wp[AW] != st.rp[AW]) &&
                    (st.wp[AW-1:0] == st.rp[AW-1:0]);
  assign empty    = (st.wp == st.rp);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = st.mem[st.rp[AW-1:0]];

  // Push and pop
  always_comb begin
    nx = st;
    if (inValid && !full) begin
      nx.mem[st.wp[AW-1:0]] = inData;
      nx.wp = st.wp + 1'b1;
    end
    if (outReady && !empty) begin
      nx.rp = st.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  fifo_level_bound_a: assert property (
    (st.wp - st.rp) <= (AW+1)'(DEPTH))
    else $error("fifo level above depth");

endmodule // hpq_fifo

// [hw/hpq_top.sv]
// Transmit queue manager and frame framing behind the host register port.
// Assumes host strobes and address are synchronous to sys_clk.
//
// What this block does
// - Frame is control, count, then data
// - CRC bit says whether data holds FCS
// - Header words byte-swapped in big endian
// - Status shows frame now leaving
// - Control bit 15 raises done interrupt
// - Frame tag copied into transmit status
// - Frame bytes pass through unchanged
// - Control register enables transmit options
// - Free memory counts unused queue bytes
// - Manual enqueue bit clears when sent
// - Space request raises space interrupt
// - Auto enqueue queues every prepared frame
// - DMA bit opens data register access
// - Pointer advances on data access
// - Enable bits gate interrupts to pin
// - Writing one clears status bit
// - Several frames may be queued
// - Receive header status then count
// - Receive data follows, at most 2000
// - Receive pointer bit 11 or strap picks endian mode
`timescale 1ns/1ps
`include "hpq_regs.svh"
module hpq_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Host bus
  input  wire logic        aen,
  input  wire logic [7:1]  addr,
  input  wire logic        busRdN,
  input  wire logic        busWrN,
  input  wire logic [15:0] busDataIn,
  output logic      [15:0] busDataOut,
  output logic             busDataOeN,
  output logic             busWaitN,
  output logic             intrN,
  // Strap
  input  wire logic        endianStrap,
  // Transmit stream to the MAC
  output logic      [15:0] macData,
  output logic             macValid,
  output logic             macLast,
  input  wire logic        macReady,
  output logic      [15:0] txOptions,
  // Receive frame from the MAC side
  input  wire logic        rxFrameValid,
  input  wire logic [15:0] rxStatusWord,
  input  wire logic [10:0] rxByteCount,
  input  wire logic [15:0] rxWord,
  output logic             rxWordPop,
  output logic             rxFrameDone
);

  hpq_pkg::hpq_state_t st;
  hpq_pkg::hpq_state_t nx;

  logic        fifoInReady;
  logic        fifoOutValid;
  logic [15:0] fifoOutData;
  logic        fifoPop;

  // Byte swap of a header word in big endian mode
  function automatic logic [15:0] swapIf(input logic big,
                                         input logic [15:0] w);
    swapIf = big ? {w[7:0], w[15:8]} : w;
  endfunction

  // Queue bytes of one frame: header plus data, on a 4-byte boundary
  function automatic logic [12:0] frameBytes(input logic [10:0] len);
    logic [12:0] s;
    s = {2'b00, len} + 13'h0007;
    frameBytes = {s[12:2], 2'b00};
  endfunction

  // Number of 16-bit words holding len bytes
  function automatic logic [10:0] wordsOf(input logic [10:0] len);
    logic [11:0] s;
    s = {1'b0, len} + 12'h001;
    wordsOf = s[11:1];
  endfunction

  hpq_fifo #(
    .WIDTH (16),
    .DEPTH (32)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .inValid  (st.fifoPush),
    .inData   (st.fifoWord),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoPop)
  );

  logic        bigEnd;
  logic        wrFall;
  logic        rdRise;
  logic [7:0]  ofs;
  logic        dmaOn;
  logic        manualReq;
  logic [12:0] reserveBytes;
  logic [12:0] releaseBytes;
  logic        doneEvt;
  logic        spaceEvt;
  logic [15:0] hdr;
  logic [15:0] isClr;
  logic [10:0] rxLen;

  // Next state of the whole block
  always_comb begin
    nx = st;
    bigEnd = endianStrap | st.rxPtr[`HPQ_PTR_BIGEND];
    wrFall = st.wrPrev & ~busWrN;
    rdRise = ~st.rdPrev & busRdN;
    ofs = {addr, 1'b0};
    dmaOn = st.rxQCmd[`HPQ_RXQ_DMA];
    manualReq = 1'b0;
    reserveBytes = 13'h0000;
    releaseBytes = 13'h0000;
    doneEvt = 1'b0;
    spaceEvt = 1'b0;
    isClr = 16'h0000;
    fifoPop = 1'b0;
    hdr = swapIf(bigEnd, busDataIn);
    rxLen = (rxByteCount > `HPQ_MAX_BYTES) ? `HPQ_MAX_BYTES
                                            : rxByteCount;
    nx.wrPrev = busWrN;
    nx.rdPrev = busRdN;
    nx.fifoPush = 1'b0;
    nx.rxPop = 1'b0;
    nx.rxDone = 1'b0;

    // Register writes on the falling edge of the write strobe
    if (wrFall && !aen) begin
      case (ofs)
        `HPQ_TXCTL_OFS: begin
          nx.txCtl = busDataIn & `HPQ_TXCTL_MASK;
        end
        `HPQ_TXQCMD_OFS: begin
          manualReq = busDataIn[`HPQ_TXQ_MANUAL];
          nx.txQCmd[`HPQ_TXQ_SPACE] = st.txQCmd[`HPQ_TXQ_SPACE] |
                                      busDataIn[`HPQ_TXQ_SPACE];
          nx.txQCmd[`HPQ_TXQ_AUTO] = busDataIn[`HPQ_TXQ_AUTO];
        end
        `HPQ_RXQCMD_OFS: nx.rxQCmd = busDataIn;
        `HPQ_TXPTR_OFS: nx.txPtr = busDataIn & `HPQ_TXPTR_MASK;
        `HPQ_RXPTR_OFS: nx.rxPtr = busDataIn & `HPQ_RXPTR_MASK;
        `HPQ_IEN_OFS: nx.iEn = busDataIn;
        `HPQ_ISTAT_OFS: isClr = busDataIn;
        `HPQ_TXREQ_OFS: nx.txReq = busDataIn;
        `HPQ_DATA_OFS: begin
          if (dmaOn) begin
            nx.fifoPush = 1'b1;
            nx.fifoWord = busDataIn;
            if (st.txPtr[`HPQ_PTR_AUTOINC]) begin
              nx.txPtr[10:0] = st.txPtr[10:0] + `HPQ_PTR_STEP;
            end
            // Parse the frame as it is written
            case (st.fill)
              hpq_pkg::FL_CTRL: nx.fill = hpq_pkg::FL_LEN;
              hpq_pkg::FL_LEN: begin
                reserveBytes = frameBytes(hdr[`HPQ_LEN_MSB:0]);
                nx.prepared = st.prepared + 6'h01;
                nx.fillLeft = wordsOf(hdr[`HPQ_LEN_MSB:0]);
                nx.fill = hpq_pkg::FL_DATA;
              end
              hpq_pkg::FL_DATA: begin
                nx.fillLeft = st.fillLeft - 11'h001;
                if (st.fillLeft <= 11'h001) begin
                  nx.fill = hpq_pkg::FL_CTRL;
                end
              end
              default: nx.fill = hpq_pkg::FL_CTRL;
            endcase
          end
        end
        default: ;
      endcase
    end

    // Receive frame reads advance on the rising edge of the read strobe
    if (rdRise && !aen && ofs == `HPQ_DATA_OFS && dmaOn && rxFrameValid) begin
      if (st.rxPtr[`HPQ_PTR_AUTOINC]) begin
        nx.rxPtr[10:0] = st.rxPtr[10:0] + `HPQ_PTR_STEP;
      end
      case (st.rxPh)
        hpq_pkg::RX_STAT: nx.rxPh = hpq_pkg::RX_LEN;
        hpq_pkg::RX_LEN: begin
          nx.rxLeft = wordsOf(rxLen);
          nx.rxPh = hpq_pkg::RX_DATA;
        end
        hpq_pkg::RX_DATA: begin
          nx.rxPop = 1'b1;
          nx.rxLeft = st.rxLeft - 11'h001;
          if (st.rxLeft <= 11'h001) begin
            nx.rxDone = 1'b1;
            nx.rxPh = hpq_pkg::RX_STAT;
          end
        end
        default: nx.rxPh = hpq_pkg::RX_STAT;
      endcase
    end

    // Drain queued frames toward the MAC
    if (st.macValid && macReady) begin
      nx.macValid = 1'b0;
    end
    case (st.drain)
      hpq_pkg::DR_IDLE: begin
        if (st.queued != 6'h00 && st.txCtl[`HPQ_TXCTL_EN]) begin
          nx.drain = hpq_pkg::DR_CTRL;
        end
      end
      hpq_pkg::DR_CTRL: begin
        if (fifoOutValid) begin
          fifoPop = 1'b1;
          nx.drainCtl = swapIf(bigEnd, fifoOutData);
          nx.txStat = swapIf(bigEnd, fifoOutData) & 16'h003f;
          nx.drain = hpq_pkg::DR_LEN;
        end
      end
      hpq_pkg::DR_LEN: begin
        if (fifoOutValid) begin
          fifoPop = 1'b1;
          hdr = swapIf(bigEnd, fifoOutData);
          nx.drainLen = hdr[`HPQ_LEN_MSB:0];
          nx.drainLeft = wordsOf(hdr[`HPQ_LEN_MSB:0]);
          nx.drain = (hdr[`HPQ_LEN_MSB:0] == 11'h000) ? hpq_pkg::DR_DONE
                                                      : hpq_pkg::DR_DATA;
        end
      end
      hpq_pkg::DR_DATA: begin
        if (fifoOutValid && (!st.macValid || macReady)) begin
          fifoPop = 1'b1;
          nx.macData = fifoOutData;
          nx.macValid = 1'b1;
          nx.macLast = (st.drainLeft == 11'h001);
          nx.drainLeft = st.drainLeft - 11'h001;
          if (st.drainLeft == 11'h001) begin
            nx.drain = hpq_pkg::DR_DONE;
          end
        end
      end
      hpq_pkg::DR_DONE: begin
        if (!st.macValid) begin
          releaseBytes = frameBytes(st.drainLen);
          nx.queued = st.queued - 6'h01;
          doneEvt = st.drainCtl[`HPQ_CTL_IRQ];
          nx.txQCmd[`HPQ_TXQ_MANUAL] = 1'b0;
          nx.drain = hpq_pkg::DR_IDLE;
        end
      end
      default: nx.drain = hpq_pkg::DR_IDLE;
    endcase

    // Manual enqueue of one prepared frame
    if (manualReq && !st.txQCmd[`HPQ_TXQ_MANUAL] && nx.prepared != 6'h00) begin
      nx.queued = nx.queued + 6'h01;
      nx.prepared = nx.prepared - 6'h01;
      nx.txQCmd[`HPQ_TXQ_MANUAL] = 1'b1;
    end
    // Auto enqueue moves every prepared frame
    if (nx.txQCmd[`HPQ_TXQ_AUTO]) begin
      nx.queued = nx.queued + nx.prepared;
      nx.prepared = 6'h00;
    end

    // Free memory and space request
    nx.freeMem = st.freeMem - reserveBytes + releaseBytes;
    if (st.txQCmd[`HPQ_TXQ_SPACE] &&
        {5'b00000, st.freeMem} >= {st.txReq, 2'b00}) begin
      spaceEvt = 1'b1;
      nx.txQCmd[`HPQ_TXQ_SPACE] = 1'b0;
    end

    // Interrupt status: a set wins over a clear in the same cycle
    nx.iStat = st.iStat & ~isClr;
    if (doneEvt) begin
      nx.iStat[`HPQ_IRQ_TXDONE] = 1'b1;
    end
    if (spaceEvt) begin
      nx.iStat[`HPQ_IRQ_SPACE] = 1'b1;
    end
    nx.intrN = ~|(nx.iStat & nx.iEn);

    // Read data drive while the read strobe is low
    nx.busOeN = 1'b1;
    nx.busOut = `HPQ_RESET_WORD;
    if (!busRdN && !aen) begin
      nx.busOeN = 1'b0;
      case (ofs)
        `HPQ_TXCTL_OFS: nx.busOut = st.txCtl;
        `HPQ_TXSTAT_OFS: nx.busOut = st.txStat;
        `HPQ_TXFREE_OFS: nx.busOut = {3'b000, st.freeMem};
        `HPQ_TXQCMD_OFS: nx.busOut = st.txQCmd;
        `HPQ_RXQCMD_OFS: nx.busOut = st.rxQCmd;
        `HPQ_TXPTR_OFS: nx.busOut = st.txPtr;
        `HPQ_RXPTR_OFS: nx.busOut = st.rxPtr;
        `HPQ_IEN_OFS: nx.busOut = st.iEn;
        `HPQ_ISTAT_OFS: nx.busOut = st.iStat;
        `HPQ_TXREQ_OFS: nx.busOut = st.txReq;
        `HPQ_DATA_OFS: begin
          if (dmaOn && rxFrameValid) begin
            case (st.rxPh)
              hpq_pkg::RX_STAT: nx.busOut = swapIf(bigEnd, rxStatusWord);
              hpq_pkg::RX_LEN: nx.busOut = swapIf(bigEnd, {5'b00000, rxLen});
              default: nx.busOut = rxWord;
            endcase
          end
        end
        default: nx.busOut = `HPQ_RESET_WORD;
      endcase
    end
    nx.waitN = fifoInReady;
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.wrPrev <= 1'b1;
      st.rdPrev <= 1'b1;
      st.freeMem <= `HPQ_TXQ_BYTES;
      st.fill <= hpq_pkg::FL_CTRL;
      st.drain <= hpq_pkg::DR_IDLE;
      st.rxPh <= hpq_pkg::RX_STAT;
      st.busOeN <= 1'b1;
      st.intrN <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register
  assign busDataOut  = st.busOut;
  assign busDataOeN  = st.busOeN;
  assign busWaitN    = st.waitN;
  assign intrN       = st.intrN;
  assign macData     = st.macData;
  assign macValid    = st.macValid;
  assign macLast     = st.macLast;
  assign txOptions   = st.txCtl;
  assign rxWordPop   = st.rxPop;
  assign rxFrameDone = st.rxDone;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  intr_pin_gate_a: assert property (
    intrN == ~|(st.iStat & st.iEn))
    else $error("interrupt pin not matching enabled status");

  status_clear_a: assert property (
    (wrFall && !aen && ofs == `HPQ_ISTAT_OFS &&
     busDataIn[`HPQ_IRQ_TXDONE] && !doneEvt)
    |=> !st.iStat[`HPQ_IRQ_TXDONE])
    else $error("status bit not cleared by write of one");

  done_irq_a: assert property (
    (st.drain == hpq_pkg::DR_DONE && !st.macValid &&
     st.drainCtl[`HPQ_CTL_IRQ])
    |=> st.iStat[`HPQ_IRQ_TXDONE] && st.drain == hpq_pkg::DR_IDLE)
    else $error("done interrupt missing after flagged frame");

  space_irq_a: assert property (
    (st.txQCmd[`HPQ_TXQ_SPACE] &&
     {5'b00000, st.freeMem} >= {st.txReq, 2'b00})
    |=> st.iStat[`HPQ_IRQ_SPACE] && !st.txQCmd[`HPQ_TXQ_SPACE])
    else $error("space interrupt missing when space met");

  manual_clear_a: assert property (
    (st.drain == hpq_pkg::DR_DONE && !st.macValid)
    |=> !st.txQCmd[`HPQ_TXQ_MANUAL])
    else $error("manual enqueue bit not cleared after frame");

  free_bound_a: assert property (
    st.freeMem <= `HPQ_TXQ_BYTES)
    else $error("free memory above queue size");

  tag_capture_a: assert property (
    (st.drain == hpq_pkg::DR_CTRL && fifoOutValid)
    |=> st.txStat[5:0] == $past(swapIf(bigEnd, fifoOutData) & 16'h003f)
        && st.drain == hpq_pkg::DR_LEN)
    else $error("frame tag not copied to status");

  ptr_autoinc_a: assert property (
    (wrFall && !aen && ofs == `HPQ_DATA_OFS && dmaOn &&
     st.txPtr[`HPQ_PTR_AUTOINC])
    |=> st.txPtr[10:0] == $past(st.txPtr[10:0]) + `HPQ_PTR_STEP)
    else $error("transmit pointer did not advance");

  tx_disabled_a: assert property (
    (st.drain == hpq_pkg::DR_IDLE && !st.txCtl[`HPQ_TXCTL_EN])
    |=> st.drain == hpq_pkg::DR_IDLE)
    else $error("drain started with transmit disabled");

  auto_enqueue_a: assert property (
    (wrFall && !aen && ofs == `HPQ_DATA_OFS && dmaOn &&
     st.fill == hpq_pkg::FL_LEN && st.txQCmd[`HPQ_TXQ_AUTO] &&
     st.drain != hpq_pkg::DR_DONE)
    |=> st.queued == $past(st.queued) + 6'h01 && st.prepared == 6'h00)
    else $error("prepared frame left behind in auto mode");

  data_pass_a: assert property (
    (st.drain == hpq_pkg::DR_DATA && fifoPop)
    |=> macValid && macData == $past(fifoOutData))
    else $error("frame word altered on way to MAC");

endmodule // hpq_top

// [dv/hpq_mac_model.sv]
// Behavioural MAC side of the queue block: accepts transmit words with
// random stalls and presents one received frame on request.
`timescale 1ns/1ps
module hpq_mac_model #(
  parameter logic [15:0] STATUS = 16'h8012,
  parameter logic [10:0] COUNT  = 11'h006
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Transmit stream
  input  wire logic        stall,
  output logic             macReady,
  // Receive frame
  input  wire logic        rxStart,
  input  wire logic        rxWordPop,
  input  wire logic        rxFrameDone,
  output logic             rxFrameValid,
  output logic      [15:0] rxStatusWord,
  output logic      [10:0] rxByteCount,
  output logic      [15:0] rxWord
);
  // Header lines show the inverse when no frame is presented
  assign rxStatusWord = rxFrameValid ? STATUS : ~STATUS;
  assign rxByteCount  = rxFrameValid ? COUNT : ~COUNT;

  // Stall pattern and receive word sequence
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      macReady     <= 1'b0;
      rxFrameValid <= 1'b0;
      rxWord       <= 16'h0000;
    end else begin
      macReady <= ~stall;
      if (rxStart) begin
        rxFrameValid <= 1'b1;
        rxWord       <= 16'h5a00;
      end else if (rxFrameDone) begin
        rxFrameValid <= 1'b0;
        rxWord       <= ~rxWord;
      end else if (rxWordPop) begin
        rxWord <= rxWord + 16'h0001;
      end else if (!rxFrameValid) begin
        rxWord <= ~rxWord; // Idle data never holds still
      end
    end
  end
endmodule // hpq_mac_model

// [dv/tb.sv]
// Self-checking bench of the queue block: register port, two transmit
// paths, space request, interrupts and a big-endian receive read.
// Assumes the MAC model in its own file.
`timescale 1ns/1ps
module tb;
  logic        sys_clk, reset, aen, busRdN, busWrN, endianStrap;
  logic [7:1]  addr;
  logic [15:0] busDataIn, busDataOut, macData, txOptions;
  logic [15:0] rxStatusWord, rxWord;
  logic [10:0] rxByteCount;
  logic        busDataOeN, busWaitN, intrN, macValid, macLast, macReady;
  logic        rxFrameValid, rxWordPop, rxFrameDone, stall, rxStart;
  logic [31:0] rnd;
  logic [16:0] e;
  logic [15:0] rdQ[$];
  logic [16:0] macQ[$];
  int          n_mismatch, compares, cycles;
  bit          doneSeen;

  hpq_top i_hpq_top (.sys_clk(sys_clk), .reset(reset), .aen(aen),
    .addr(addr), .busRdN(busRdN), .busWrN(busWrN), .busDataIn(busDataIn),
    .busDataOut(busDataOut), .busDataOeN(busDataOeN),
    .busWaitN(busWaitN), .intrN(intrN), .endianStrap(endianStrap),
    .macData(macData), .macValid(macValid), .macLast(macLast),
    .macReady(macReady), .txOptions(txOptions),
    .rxFrameValid(rxFrameValid), .rxStatusWord(rxStatusWord),
    .rxByteCount(rxByteCount), .rxWord(rxWord), .rxWordPop(rxWordPop),
    .rxFrameDone(rxFrameDone));

  hpq_mac_model i_hpq_mac_model (.sys_clk(sys_clk), .reset(reset),
    .stall(stall), .macReady(macReady), .rxStart(rxStart),
    .rxWordPop(rxWordPop), .rxFrameDone(rxFrameDone),
    .rxFrameValid(rxFrameValid), .rxStatusWord(rxStatusWord),
    .rxByteCount(rxByteCount), .rxWord(rxWord));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Register write: strobe low one edge, then three idle cycles
  task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
    @(posedge sys_clk);
    addr      <= ofs[7:1];
    busDataIn <= d;
    busWrN    <= 1'b0;
    @(posedge sys_clk);
    busWrN <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  // Register read: expectation noted, data taken by the watcher
  task automatic rd(input logic [7:0] ofs, input logic [15:0] exp);
    rdQ.push_back(exp);
    @(posedge sys_clk);
    addr   <= ofs[7:1];
    busRdN <= 1'b0;
    repeat (2) @(posedge sys_clk);
    busRdN <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  // Frame into the queue; waits for room before each data word
  task automatic frame(input logic [15:0] ctl, input logic [10:0] cnt,
                       input bit rndData, input bit big = 1'b0);
    logic [15:0] w;
    int          k;
    bit          refused;
    refused = 0;
    wr(8'hd0, big ? {ctl[7:0], ctl[15:8]} : ctl);
    wr(8'hd0, big ? {cnt[7:0], 5'b0, cnt[10:8]} : {5'b0, cnt});
    for (int i = 0; i < (cnt + 1) / 2; i++) begin
      #1;
      w = rndData ? rnd[15:0] : 16'h1100 + i[15:0];
      macQ.push_back({i == (cnt + 1) / 2 - 1, w});
      if (busWaitN !== 1'b1 && !refused) begin
        refused = 1;
        check("fill", 16'h001e, i[15:0]);
        wr(8'h70, 16'h0003);
      end
      k = 0;
      while (busWaitN !== 1'b1 && k < 400) begin
        @(posedge sys_clk);
        k++;
      end
      check("wait", 16'h0001, {15'b0, busWaitN});
      wr(8'hd0, w);
    end
    if (rndData) check("refused", 16'h0001, {15'b0, refused});
  endtask

  // Waits for the transmit stream to drain
  task automatic drained();
    int k;
    k = 0;
    while (macQ.size() > 0 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    check("drain", 16'h0000, 16'(macQ.size()));
    repeat (10) @(posedge sys_clk);
  endtask

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Random stall source and timeout
  always @(posedge sys_clk) begin
    rnd   <= lfsr(rnd);
    stall <= rnd[0];
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Read data watcher
  always @(negedge busDataOeN) begin
    #1;
    if (!reset) begin
      if (rdQ.size() > 0) check("read", rdQ.pop_front(), busDataOut);
      else check("read_extra", 16'h0000, 16'h0001);
    end
  end

  // Transmit stream watcher
  always @(posedge sys_clk) begin
    if (rxFrameDone === 1'b1) doneSeen = 1;
    if (macValid === 1'b1 && macReady === 1'b1) begin
      if (macQ.size() == 0) check("mac_extra", 16'h0000, 16'h0001);
      else begin
        e = macQ.pop_front();
        check("mac_data", e[15:0], macData);
        check("mac_last", {15'b0, e[16]}, {15'b0, macLast});
      end
    end
  end

  // Main sequence
  initial begin
    {aen, addr, busDataIn, endianStrap, rxStart, stall} = '0;
    {busRdN, busWrN, reset} = 3'b111;
    rnd = 32'h3385_8050;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(8'h78, 16'h1800);
    rd(8'h70, 16'h0000);
    rd(8'h40, 16'h0000);
    wr(8'h70, 16'hffff);
    rd(8'h70, 16'h01ef);
    check("options", 16'h01ef, txOptions);
    wr(8'h70, 16'h0003);
    // Space request beyond the queue, then one that fits
    wr(8'h9e, 16'h0601);
    wr(8'h80, 16'h0002);
    repeat (10) @(posedge sys_clk);
    rd(8'h80, 16'h0002);
    rd(8'h92, 16'h0000);
    wr(8'h9e, 16'h0600);
    repeat (5) @(posedge sys_clk);
    rd(8'h92, 16'h0040);
    rd(8'h80, 16'h0000);
    check("irq_masked", 16'h0001, {15'b0, intrN});
    wr(8'h90, 16'h4040);
    repeat (3) @(posedge sys_clk);
    #1 check("irq_on", 16'h0000, {15'b0, intrN});
    wr(8'h92, 16'hffff);
    repeat (3) @(posedge sys_clk);
    #1 check("irq_off", 16'h0001, {15'b0, intrN});
    rd(8'h92, 16'h0000);
    // Manual enqueue of one odd-length frame
    wr(8'h82, 16'h0008);
    wr(8'h84, 16'h4000);
    frame(16'h8015, 11'h005, 0);
    rd(8'h78, 16'h17f4);
    rd(8'h84, 16'h400a);
    wr(8'h80, 16'h0001);
    drained();
    rd(8'h80, 16'h0000);
    rd(8'h72, 16'h0015);
    rd(8'h92, 16'h4000);
    check("irq_done", 16'h0000, {15'b0, intrN});
    rd(8'h78, 16'h1800);
    wr(8'h92, 16'h4000);
    // Auto enqueue, transmitter off until the FIFO refuses
    wr(8'h70, 16'h0000);
    wr(8'h80, 16'h0004);
    frame(16'h002a, 11'h050, 1);
    frame(16'h0003, 11'h004, 0);
    drained();
    rd(8'h72, 16'h0003);
    rd(8'h78, 16'h1800);
    rd(8'h92, 16'h0000);
    // Big-endian receive read
    wr(8'h86, 16'h0800);
    frame(16'h0005, 11'h004, 0, 1);
    drained();
    rd(8'h72, 16'h0005);
    rxStart <= 1'b1;
    @(posedge sys_clk);
    rxStart <= 1'b0;
    rd(8'hd0, 16'h1280);
    rd(8'hd0, 16'h0600);
    for (int i = 0; i < 3; i++) rd(8'hd0, 16'h5a00 + i[15:0]);
    #1 check("rx_done", 16'h0001, {15'b0, doneSeen});
    conclude();
  end
endmodule // tb
